// file: common/lowside_pwm_cfg.svh
`ifndef LOWSIDE_PWM_CFG_SVH
`define LOWSIDE_PWM_CFG_SVH

// clock rate of mclk
`define MCLK_HZ 250000000
// pwm period is split into this many duty steps
`define PWM_STEPS 256
// quarter period offset between neighbouring channels, in steps
`define PHASE_QUARTER 8'h40

// output frequency per select code, in units of 100 Hz
`define FREQ_SEL0_HHZ 39
`define FREQ_SEL1_HHZ 42
`define FREQ_SEL2_HHZ 45
`define FREQ_SEL3_HHZ 50
`define FREQ_SEL4_HHZ 36
`define FREQ_SEL5_HHZ 34
`define FREQ_SEL6_HHZ 32
`define FREQ_SEL7_HHZ 30
`define HHZ_TO_HZ 100

// reset values
`define FREQ_SEL_RESET 3'h0
`define DUTY_RESET 8'h00
`define TARGET_RESET 10'h000
`define KI_RESET 4'h1
`define KP_RESET 4'h1

// codes with fixed meaning
`define DUTY_FULL_ON 8'hff
`define DUTY_OFF 8'h00
// smallest duty an armed regulator applies, so that it keeps seeing on-phase samples
`define DUTY_MIN_ON 8'h01
`define TARGET_OFF 10'h000

// regulator scaling: gains in eighths, 10-bit current to 8-bit duty
`define REG_SHIFT 5
`define INTEG_MAX 20'sh01fe0

`endif

// file: common/lowside_pwm_pkg.sv
`include "lowside_pwm_cfg.svh"

package lowside_pwm_pkg;

    typedef logic [7:0] duty_t;
    typedef logic [9:0] current_t;
    typedef logic [2:0] freq_sel_t;
    typedef logic [3:0] gain_t;
    typedef logic [11:0] prescale_t;

    // clocks per duty step for a frequency select code
    function automatic prescale_t freq_prescale(input freq_sel_t sel);
        int hhz;
        case (sel)
            3'h0: hhz = `FREQ_SEL0_HHZ;
            3'h1: hhz = `FREQ_SEL1_HHZ;
            3'h2: hhz = `FREQ_SEL2_HHZ;
            3'h3: hhz = `FREQ_SEL3_HHZ;
            3'h4: hhz = `FREQ_SEL4_HHZ;
            3'h5: hhz = `FREQ_SEL5_HHZ;
            3'h6: hhz = `FREQ_SEL6_HHZ;
            default: hhz = `FREQ_SEL7_HHZ;
        endcase
        return prescale_t'(`MCLK_HZ / (hhz * `HHZ_TO_HZ * `PWM_STEPS));
    endfunction : freq_prescale

endpackage : lowside_pwm_pkg

// file: hw/pwm_phase_timer.sv
`timescale 1ns/10ps

module pwm_phase_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire lowside_pwm_pkg::prescale_t prescale,
    output logic [3:0][7:0] phase_cnt
);
    import lowside_pwm_pkg::*;

    prescale_t pre_cnt_reg;
    duty_t base_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // step prescaler; a shorter prescale takes effect at once, and a count already past it wraps on the next clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pre_cnt_reg <= 12'h000;
        end else if (pre_cnt_reg >= prescale - 12'h001) begin
            pre_cnt_reg <= 12'h000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 12'h001;
        end
    end

    // period counter of the first channel
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            base_cnt_reg <= 8'h00;
        end else if (pre_cnt_reg >= prescale - 12'h001) begin
            base_cnt_reg <= base_cnt_reg + 8'h01;
        end
    end

    // each later channel lags the one before by a quarter period
    for (genvar i = 0; i < 4; i++) begin : g_phase
        assign phase_cnt[i] = base_cnt_reg - 8'(i * `PHASE_QUARTER);
    end

    ////////////////////////////////////////////////////////////////////////
    AST_PRESCALE_BOUND: assert property (@(posedge mclk) disable iff (!rst_n)
        (prescale == $past(prescale)) |-> (pre_cnt_reg < prescale))
        else $error("prescaler ran past its limit");

    for (genvar i = 1; i < 4; i++) begin : g_phase_chk
        AST_QUARTER_LAG: assert property (@(posedge mclk) disable iff (!rst_n)
            phase_cnt[i] == phase_cnt[i-1] - `PHASE_QUARTER)
            else $error("channel phase is not a quarter period behind");
    end

endmodule : pwm_phase_timer

// file: hw/pi_regulator.sv
`timescale 1ns/10ps

module pi_regulator (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire lowside_pwm_pkg::current_t target,
    input wire logic sample_stb,
    input wire lowside_pwm_pkg::current_t sample,
    input wire lowside_pwm_pkg::gain_t ki,
    input wire lowside_pwm_pkg::gain_t kp,
    output lowside_pwm_pkg::duty_t duty
);
    import lowside_pwm_pkg::*;

    logic signed [10:0] err;
    logic signed [15:0] i_step;
    logic signed [15:0] p_term;
    logic signed [19:0] integ_reg;
    logic signed [19:0] integ_next;
    logic signed [19:0] out_sum;
    logic signed [19:0] out_scaled;

    ////////////////////////////////////////////////////////////////////////
    // error against the live target, so a new target acts at once
    assign err = $signed({1'b0, target}) - $signed({1'b0, sample});
    assign i_step = err * $signed({1'b0, ki});
    assign p_term = err * $signed({1'b0, kp});

    // integrator clamped to the duty range to stop wind-up
    always_comb begin
        integ_next = integ_reg + 20'(i_step);
        if (integ_next < 20'sh00000) begin
            integ_next = 20'sh00000;
        end else if (integ_next > `INTEG_MAX) begin
            integ_next = `INTEG_MAX;
        end
        out_sum = integ_next + 20'(p_term);
        out_scaled = out_sum >>> `REG_SHIFT;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin
            integ_reg <= 20'sh00000;
        end else if (sample_stb) begin
            integ_reg <= integ_next;
        end
    end

    // duty follows each on-phase sample, saturated to 0..255
    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin
            duty <= `DUTY_OFF;
        end else if (sample_stb) begin
            if (out_scaled < 20'sh00000) begin
                duty <= 8'h00;
            end else if (out_scaled > 20'sh000ff) begin
                duty <= 8'hff;
            end else begin
                duty <= out_scaled[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_IDLE_NO_DUTY: assert property (@(posedge mclk) disable iff (!rst_n)
        !enable |=> (duty == `DUTY_OFF))
        else $error("regulator drove duty while idle");

endmodule : pi_regulator

// file: hw/lowside_pwm_current_regulator.sv
`timescale 1ns/10ps

// Summary of operation
// - four 8-bit duty registers, 0.39% per step
// - digital duty all ones keeps switch on
// - digital duty zero keeps switch off
// - channels staggered by a quarter period
// - select resets to 000, 3.9 kHz; up to 5.0
// - slope bit set selects faster edges
// - four 10-bit targets, 2.2 mA per step
// - zero target disables the power stage in current mode
// - all-ones target means 2.250 A
// - new target acts in regulator at once
// - PI regulator steers duty from current error
// - regulation sample taken during on phase
// - current mode, select clear: read target
// - current mode, select set: read applied duty
// - digital mode, select clear: read duty code
// - digital mode, select set: read measured current
// - regulators idle until nonzero integral gain; default 1/8
module lowside_pwm_current_regulator (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] duty_wr_en,
    input wire lowside_pwm_pkg::duty_t duty_wr_data,
    input wire logic [3:0] target_wr_en,
    input wire lowside_pwm_pkg::current_t target_wr_data,
    input wire logic freq_wr_en,
    input wire lowside_pwm_pkg::freq_sel_t pwm_freq_select,
    input wire logic ki_wr_en,
    input wire lowside_pwm_pkg::gain_t ki_wr_data,
    input wire logic kp_wr_en,
    input wire lowside_pwm_pkg::gain_t kp_wr_data,
    input wire logic slope_select,
    input wire logic [1:0] regulation_disable_pair,
    input wire logic readback_select,
    input wire logic [3:0] adc_valid,
    input wire logic [3:0][9:0] adc_current,
    output logic [3:0] lowside_channel,
    output logic slope_fast,
    output logic [3:0][9:0] readback
);
    import lowside_pwm_pkg::*;

    freq_sel_t freq_sel_reg;
    gain_t ki_reg;
    gain_t kp_reg;
    logic ki_armed_reg;
    prescale_t prescale;
    logic [3:0][7:0] phase_cnt;
    duty_t duty_reg [4];
    current_t target_reg [4];
    current_t adc_last_reg [4];
    duty_t reg_duty [4];
    duty_t duty_eff [4];
    logic [3:0] digital_mode;
    logic [3:0] sample_stb;

    // pair 0 covers channels one and two, pair 1 the other two
    function automatic logic pair_digital(input logic [1:0] dis, input int ch);
        return dis[ch / 2];
    endfunction : pair_digital

    ////////////////////////////////////////////////////////////////////////
    // shared configuration

    // frequency select is held so that it has a defined reset code
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            freq_sel_reg <= `FREQ_SEL_RESET;
        end else if (freq_wr_en) begin
            freq_sel_reg <= pwm_freq_select;
        end
    end

    // table lookup of clocks per duty step
    assign prescale = freq_prescale(freq_sel_reg);

    // integral gain defaults to one eighth but stays unarmed until written
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ki_reg <= `KI_RESET;
            ki_armed_reg <= 1'b0;
        end else if (ki_wr_en) begin
            ki_reg <= ki_wr_data;
            ki_armed_reg <= (ki_wr_data != 4'h0);
        end
    end

    // proportional gain, in eighths
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            kp_reg <= `KP_RESET;
        end else if (kp_wr_en) begin
            kp_reg <= kp_wr_data;
        end
    end

    // one slope setting for all four drivers; the edge rate itself is analog
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slope_fast <= 1'b0;
        end else begin
            slope_fast <= slope_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period counters, one shared prescaler

    pwm_phase_timer u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .prescale(prescale),
        .phase_cnt(phase_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-channel logic

    for (genvar i = 0; i < 4; i++) begin : g_ch

        assign digital_mode[i] = pair_digital(regulation_disable_pair, i);

        // only samples caught while the switch conducts see the load current
        assign sample_stb[i] = adc_valid[i] && lowside_channel[i] && !digital_mode[i];

        // duty code register
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                duty_reg[i] <= `DUTY_RESET;
            end else if (duty_wr_en[i]) begin
                duty_reg[i] <= duty_wr_data;
            end
        end

        // target current register, full scale all ones
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                target_reg[i] <= `TARGET_RESET;
            end else if (target_wr_en[i]) begin
                target_reg[i] <= target_wr_data;
            end
        end

        // last converter result, latched in either mode, read back in digital mode only
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                adc_last_reg[i] <= 10'h000;
            end else if (adc_valid[i]) begin
                adc_last_reg[i] <= adc_current[i];
            end
        end

        pi_regulator u_reg (
            .mclk(mclk),
            .rst_n(rst_n),
            .enable(ki_armed_reg && (target_reg[i] != `TARGET_OFF)),
            .target(target_reg[i]),
            .sample_stb(sample_stb[i]),
            .sample(adc_current[i]),
            .ki(ki_reg),
            .kp(kp_reg),
            .duty(reg_duty[i])
        );

        // zero target forces the stage off even if the regulator lags
        always_comb begin
            if (digital_mode[i]) begin
                duty_eff[i] = duty_reg[i];
            end else if (target_reg[i] == `TARGET_OFF) begin
                duty_eff[i] = `DUTY_OFF;
            end else if (ki_armed_reg && reg_duty[i] == `DUTY_OFF) begin
                // a switch that never conducts never yields a sample to regulate from
                duty_eff[i] = `DUTY_MIN_ON;
            end else begin
                duty_eff[i] = reg_duty[i];
            end
        end

        // all ones is continuous; otherwise on while counter below duty
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                lowside_channel[i] <= 1'b0;
            end else if (duty_eff[i] == `DUTY_FULL_ON) begin
                lowside_channel[i] <= 1'b1;
            end else begin
                lowside_channel[i] <= (phase_cnt[i] < duty_eff[i]);
            end
        end

        // readback multiplexer
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                readback[i] <= 10'h000;
            end else begin
                case ({digital_mode[i], readback_select})
                    2'b00: readback[i] <= target_reg[i];
                    2'b01: readback[i] <= {2'b00, duty_eff[i]};
                    2'b10: readback[i] <= {2'b00, duty_reg[i]};
                    2'b11: readback[i] <= adc_last_reg[i];
                    default: readback[i] <= 10'h000;
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////
        // checks

        sequence full_on_req_s;
            digital_mode[i] && (duty_reg[i] == `DUTY_FULL_ON);
        endsequence

        sequence full_on_held_s;
            lowside_channel[i] [*2];
        endsequence

        AST_FULL_ON: assert property (@(posedge mclk) disable iff (!rst_n)
            full_on_req_s ##1 full_on_req_s |-> full_on_held_s)
            else $error("full duty code did not hold the switch on");

        AST_ZERO_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
            (digital_mode[i] && duty_reg[i] == `DUTY_OFF) |=> !lowside_channel[i])
            else $error("zero duty code let the switch conduct");

        AST_TARGET_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
            (!digital_mode[i] && target_reg[i] == `TARGET_OFF) |=> !lowside_channel[i])
            else $error("zero target left the stage enabled");

        AST_SAMPLE_ON: assert property (@(posedge mclk) disable iff (!rst_n)
            sample_stb[i] |-> lowside_channel[i])
            else $error("regulation sample taken while switch off");

        // with the switch off an armed regulator must ignore the converter
        AST_SAMPLE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
            (!lowside_channel[i] && ki_armed_reg && target_reg[i] != `TARGET_OFF)
            |=> $stable(reg_duty[i]))
            else $error("regulator took a sample while switch off");

        AST_RB_APPLIED: assert property (@(posedge mclk) disable iff (!rst_n)
            (!digital_mode[i] && readback_select)
            |=> (readback[i] == {2'b00, $past(duty_eff[i])}))
            else $error("readback did not show the applied duty");

        AST_RB_TARGET: assert property (@(posedge mclk) disable iff (!rst_n)
            (!digital_mode[i] && !readback_select) |=> (readback[i] == $past(target_reg[i])))
            else $error("readback did not show the target");

        AST_RB_DUTY: assert property (@(posedge mclk) disable iff (!rst_n)
            (digital_mode[i] && !readback_select)
            |=> (readback[i] == {2'b00, $past(duty_reg[i])}))
            else $error("readback did not show the duty code");

        AST_RB_ADC: assert property (@(posedge mclk) disable iff (!rst_n)
            (digital_mode[i] && readback_select) |=> (readback[i] == $past(adc_last_reg[i])))
            else $error("readback did not show the measured current");

        AST_DUTY_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
            duty_wr_en[i] |=> (duty_reg[i] == $past(duty_wr_data)))
            else $error("duty write was not stored");

        AST_TARGET_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
            target_wr_en[i] |=> (target_reg[i] == $past(target_wr_data)))
            else $error("target write was not stored");

        AST_ADC_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
            adc_valid[i] |=> (adc_last_reg[i] == $past(adc_current[i])))
            else $error("converter result was not kept");
    end

    ////////////////////////////////////////////////////////////////////////
    AST_FREQ_RESET: assert property (@(posedge mclk)
        !rst_n |=> (freq_sel_reg == `FREQ_SEL_RESET))
        else $error("frequency select did not reset to its default");

    AST_KI_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ki_armed_reg && !digital_mode[0]) |=> (reg_duty[0] == `DUTY_OFF))
        else $error("regulator active before integral gain was programmed");

    AST_SLOPE: assert property (@(posedge mclk) disable iff (!rst_n)
        slope_select |=> slope_fast)
        else $error("slope output did not follow its control bit");

    AST_SLOPE_SLOW: assert property (@(posedge mclk) disable iff (!rst_n)
        !slope_select |=> !slope_fast)
        else $error("slope output stayed fast after its bit cleared");

    // a write of zero disarms, any other value arms both pairs
    AST_KI_ARM: assert property (@(posedge mclk) disable iff (!rst_n)
        ki_wr_en |=> (ki_armed_reg == ($past(ki_wr_data) != 4'h0)))
        else $error("integral gain write did not set the armed state");

    AST_KI_RESET: assert property (@(posedge mclk)
        !rst_n |=> (!ki_armed_reg && ki_reg == `KI_RESET))
        else $error("integral gain did not reset to one eighth, unarmed");

endmodule : lowside_pwm_current_regulator

// file: tb/load_model.sv
`timescale 1ns/10ps

// coil and converter on the output side: current ramps while the switch conducts
module load_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] lowside_channel,
    output logic [3:0] adc_valid,
    output logic [3:0][9:0] adc_current,
    output logic [3:0][9:0] last_sample
);
    logic [3:0] div_reg;
    logic [3:0][9:0] coil_reg;
    logic strobe;

    ////////////////////////////////////////////////////////////////////////
    // coil current: +2 per clock when on, -1 when off, saturating
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_reg <= 4'h0;
            coil_reg <= '0;
        end else begin
            div_reg <= div_reg + 4'h1;
            for (int i = 0; i < 4; i++) begin
                if (lowside_channel[i]) begin
                    coil_reg[i] <= (coil_reg[i] > 10'h3f0) ? 10'h3ff : coil_reg[i] + 10'h2;
                end else begin
                    coil_reg[i] <= (coil_reg[i] == 10'h0) ? 10'h0 : coil_reg[i] - 10'h1;
                end
            end
        end
    end

    // converter strobes every 16 clocks, in any switch phase; filtering is the block's job
    assign strobe = (div_reg == 4'hf);
    assign adc_valid = {4{strobe}};
    // outside the strobe the bus shows garbage, never the held value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            adc_current[i] = strobe ? coil_reg[i] : ~coil_reg[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // last handed-over conversion, for the bench's expectations
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_sample <= '0;
        end else if (strobe) begin
            last_sample <= coil_reg;
        end
    end
endmodule : load_model

// file: tb/lowside_pwm_current_regulator_tb.sv
`timescale 1ns/10ps

module lowside_pwm_current_regulator_tb;
    import lowside_pwm_pkg::*;
    logic mclk, rst_n, freq_wr_en, ki_wr_en, kp_wr_en, slope_select, readback_select;
    logic [3:0] duty_wr_en, target_wr_en, adc_valid, lowside_channel;
    duty_t duty_wr_data;
    current_t target_wr_data;
    freq_sel_t pwm_freq_select;
    gain_t ki_wr_data, kp_wr_data;
    logic [1:0] regulation_disable_pair;
    logic [3:0][9:0] adc_current, readback, last_sample;
    logic slope_fast;
    int errors, cmp_count, n;

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    lowside_pwm_current_regulator uut (.mclk(mclk), .rst_n(rst_n), .duty_wr_en(duty_wr_en),
        .duty_wr_data(duty_wr_data), .target_wr_en(target_wr_en),
        .target_wr_data(target_wr_data), .freq_wr_en(freq_wr_en),
        .pwm_freq_select(pwm_freq_select), .ki_wr_en(ki_wr_en), .ki_wr_data(ki_wr_data),
        .kp_wr_en(kp_wr_en), .kp_wr_data(kp_wr_data), .slope_select(slope_select),
        .regulation_disable_pair(regulation_disable_pair), .readback_select(readback_select),
        .adc_valid(adc_valid), .adc_current(adc_current), .lowside_channel(lowside_channel),
        .slope_fast(slope_fast), .readback(readback));

    load_model lm (.mclk(mclk), .rst_n(rst_n), .lowside_channel(lowside_channel),
        .adc_valid(adc_valid), .adc_current(adc_current), .last_sample(last_sample));

    ////////////////////////////////////////////////////////////////////////
    // inputs always move 1 ns after the rising edge
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick

    task check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // a wait that used up its bound is a mismatch and ends the run
    task time_out(input string msg);
        errors++;
        $display("CHECK FAILED at %0t: %s timed out", $time, msg);
        conclude();
    endtask : time_out

    // counts clocks until channel ch shows lvl; a hang ends the run
    task wait_ch(input int ch, input logic lvl, input int lim);
        n = 0;
        while (lowside_channel[ch] !== lvl && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) time_out("channel wait");
    endtask : wait_ch

    task hold_ch(input int ch, input logic lvl, input int k);
        logic ok;
        ok = 1'b1;
        repeat (k) begin
            tick(1);
            if (lowside_channel[ch] !== lvl) ok = 1'b0;
        end
        check(ok, "switch level not held");
    endtask : hold_ch

    task wr_duty(input logic [3:0] en, input duty_t d);
        duty_wr_en = en;
        duty_wr_data = d;
        tick(1);
        duty_wr_en = 4'h0;
        tick(1);
    endtask : wr_duty

    task wr_target(input logic [3:0] en, input current_t t);
        target_wr_en = en;
        target_wr_data = t;
        tick(1);
        target_wr_en = 4'h0;
        tick(1);
    endtask : wr_target

    ////////////////////////////////////////////////////////////////////////
    task test_reset;
        check(lowside_channel === 4'h0 && readback === '0 && slope_fast === 1'b0, "reset outs");
        rst_n = 1'b1;
        tick(1);
        check(readback === '0, "readback after reset");
        $display("test reset done");
    endtask : test_reset

    // digital mode: duty codes per channel, converter readback, slope bit
    task test_digital;
        regulation_disable_pair = 2'b11;
        for (int i = 0; i < 4; i++) wr_duty(4'h1 << i, duty_t'(8'h11 * (i + 1)));
        tick(1);
        for (int i = 0; i < 4; i++) check(readback[i] === 10'(8'h11 * (i + 1)), "duty rb");
        readback_select = 1'b1;
        n = 0;
        while (adc_valid[1] !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) time_out("converter strobe");
        tick(2);
        check(readback[1] === last_sample[1], "converter readback");
        readback_select = 1'b0;
        slope_select = 1'b1;
        tick(2);
        check(slope_fast === 1'b1, "fast edges");
        slope_select = 1'b0;
        tick(2);
        check(slope_fast === 1'b0, "slow edges");
        wr_duty(4'hf, 8'h40);
        $display("test digital done");
    endtask : test_digital

    // quarter duty on all channels: one conducts at a time, in order 0..3
    task test_stagger;
        wait_ch(1, 1'b1, 70000);
        check(lowside_channel === 4'b0010, "ch1 follows ch0");
        wait_ch(1, 1'b0, 20000);
        check(n >= 15998 && n <= 16002, "quarter at 3.9 kHz");
        tick(1);
        check(lowside_channel[2] === 1'b1, "ch2 follows ch1");
        freq_wr_en = 1'b1;
        pwm_freq_select = 3'h3;
        tick(1);
        freq_wr_en = 1'b0;
        wait_ch(3, 1'b1, 20000);
        check(lowside_channel === 4'b1000, "ch3 follows ch2");
        wait_ch(3, 1'b0, 20000);
        check(n >= 64 * (250000000 / (5000 * 256)) - 2 &&
              n <= 64 * (250000000 / (5000 * 256)) + 2, "quarter at 5.0 kHz");
        $display("test stagger done");
    endtask : test_stagger

    task test_full_off;
        wr_duty(4'h1, 8'hff);
        tick(2);
        hold_ch(0, 1'b1, 400);
        wr_duty(4'h1, 8'h00);
        tick(2);
        hold_ch(0, 1'b0, 400);
        $display("test full_off done");
    endtask : test_full_off

    // current mode on channel pair 0; channel two is used, its on phase comes soonest
    task test_regulator;
        regulation_disable_pair = 2'b10;
        wr_target(4'h2, 10'h3ff);
        tick(1);
        check(readback[1] === 10'h3ff, "full-scale target");
        wr_target(4'h2, 10'h1f4);
        tick(1);
        check(readback[1] === 10'h1f4, "target at once");
        readback_select = 1'b1;
        tick(300);
        check(readback[1] === 10'h0 && lowside_channel[1] === 1'b0, "idle unarmed");
        ki_wr_en = 1'b1;
        ki_wr_data = 4'h2;
        kp_wr_en = 1'b1;
        kp_wr_data = 4'h2;
        tick(1);
        ki_wr_en = 1'b0;
        kp_wr_en = 1'b0;
        tick(3);
        check(readback[1] === 10'h001, "one-step floor before first sample");
        n = 0;
        while (readback[1] <= 10'h001 && n < 15000) begin
            tick(1);
            n++;
        end
        if (n >= 15000) time_out("regulator start");
        check(readback[1] > 10'h001 && readback[1][9:8] === 2'b00, "duty steered");
        wr_target(4'h2, 10'h000);
        tick(3);
        check(readback[1] === 10'h0, "zero target duty");
        hold_ch(1, 1'b0, 300);
        $display("test regulator done");
    endtask : test_regulator

    // slowest code: a two-step pulse on a digital channel lasts two steps of 3.0 kHz
    task test_freq_low;
        freq_wr_en = 1'b1;
        pwm_freq_select = 3'h7;
        tick(1);
        freq_wr_en = 1'b0;
        wr_duty(4'h4, 8'h02);
        wait_ch(2, 1'b1, 25000);
        wait_ch(2, 1'b0, 1000);
        check(n >= 2 * (250000000 / (3000 * 256)) - 2 &&
              n <= 2 * (250000000 / (3000 * 256)) + 2, "two steps at 3.0 kHz");
        $display("test freq_low done");
    endtask : test_freq_low

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        duty_wr_en = 4'h0;
        duty_wr_data = 8'h00;
        target_wr_en = 4'h0;
        target_wr_data = 10'h000;
        freq_wr_en = 1'b0;
        pwm_freq_select = 3'h0;
        ki_wr_en = 1'b0;
        ki_wr_data = 4'h0;
        kp_wr_en = 1'b0;
        kp_wr_data = 4'h0;
        slope_select = 1'b0;
        regulation_disable_pair = 2'b11;
        readback_select = 1'b0;
        tick(20);
        test_reset();
        test_digital();
        test_stagger();
        test_full_off();
        test_regulator();
        test_freq_low();
        conclude();
    end
endmodule : lowside_pwm_current_regulator_tb
